// file: common/pos_pkg.sv
// Package for the pulse output status and HMI register bank.
// Assumes a MODBUS front end that presents one register access at a time on sys_clk.
package pos_pkg;

  // Register addresses of the bank, one 32-bit word each.
  localparam logic [15:0] POS_ADDR_FREQ_CH0  = 16'h4D00;
  localparam logic [15:0] POS_ADDR_TOTAL_CH0 = 16'h4D02;
  localparam logic [15:0] POS_ADDR_ALARM0    = 16'h4D04;
  localparam logic [15:0] POS_ADDR_AUX_A     = 16'h4D06;
  localparam logic [15:0] POS_ADDR_FREQ_CH1  = 16'h4E00;
  localparam logic [15:0] POS_ADDR_TOTAL_CH1 = 16'h4E02;
  localparam logic [15:0] POS_ADDR_ALARM1    = 16'h4E04;
  localparam logic [15:0] POS_ADDR_AUX_B     = 16'h4E06;
  localparam logic [15:0] POS_ADDR_HOLD_DLY  = 16'h6F06;

  // Zero button delay: reset value and highest accepted value, in 50 ms steps.
  localparam logic [31:0] POS_HOLD_DLY_RESET = 32'h0000_0028;
  localparam logic [31:0] POS_HOLD_DLY_MAX   = 32'h0000_00C8;
  localparam int          POS_HOLD_DLY_W     = 8;

  // Timing: step of the zero button delay and the clock rate.
  localparam int POS_STEP_MS      = 50;
  localparam int POS_CLK_MHZ      = 200;
  localparam int POS_STEP_CYCLES  = POS_STEP_MS * 1000 * POS_CLK_MHZ;

  // One register access from the MODBUS front end.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pos_req_t;

  // Answer to one register access, one cycle after it was taken.
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } pos_rsp_t;

endpackage : pos_pkg

// file: rtl/pos_regs.sv
// Status and parameter registers for two pulse channels, two alarm outputs,
// two auxiliary outputs and the zero button hold delay.
// Assumes pulse generator signals are on sys_clk; the zero button is an asynchronous pin.
//
// Overview of operation
// - Per channel read-only frequency in kHz.
// - Pulse count cleared by totalizer reset or test.
// - Pulse count read as 32-bit float.
// - Report commanded state of error alarm output.
// - Report commanded state of direction alarm output.
// - Report auxiliary output state when pulse off.
// - Test parameters act at once on write.
// - Test parameters revert to defaults after reset.
// - Zeroing starts after button held programmed delay.
// - Alarm test value 1 drives low, 0 high.
module pos_regs
  import pos_pkg::*;
#(
  parameter int STEP_CYCLES = POS_STEP_CYCLES,  // Clocks in one 50 ms step.
  parameter int CNT_W       = 32                // Width of each pulse counter.
) (
  input  wire logic        sys_clk,             // 200 MHz clock.
  input  wire logic        rst_b,               // Asynchronous reset, active low.
  input  wire pos_req_t    reg_req,             // Register access request.
  output pos_rsp_t         reg_rsp,             // Register access answer.
  input  wire logic [31:0] freq_khz_ch0,        // Channel 0 frequency, float32 kHz.
  input  wire logic [31:0] freq_khz_ch1,        // Channel 1 frequency, float32 kHz.
  input  wire logic [1:0]  pulse_emit,          // One pulse per emitted output pulse.
  input  wire logic        totalizer_clear,     // Totalizer reset pulse.
  input  wire logic        pulse_test_go_channel0, // Channel 0 test start level.
  input  wire logic        pulse_test_go_channel1, // Channel 1 test start level.
  input  wire logic [1:0]  alarm_normal,        // Alarm levels from normal operation.
  input  wire logic [1:0]  alarm_test_en,       // Alarm test start levels.
  input  wire logic [1:0]  alarm_test_val,      // Alarm test values.
  input  wire logic [1:0]  aux_state,           // Auxiliary output commanded states.
  output logic [1:0]       alarm_pin,           // Alarm output pin levels.
  input  wire logic        zero_button,         // Zero button pin, high while held.
  output logic             zero_start           // One cycle pulse: start zeroing.
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Converts an unsigned count to float32; bits below the mantissa are truncated.
  function automatic logic [31:0] pos_u2f(input logic [31:0] v);
    logic [4:0]  msb;
    logic [31:0] norm;
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        msb = 5'(i);
      end
    end
    norm = v << (5'd31 - msb);
    if (v == 32'h0000_0000) begin
      return 32'h0000_0000;
    end
    return {1'b0, 8'(8'd127 + {3'b000, msb}), norm[30:8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic [1:0] rst_sync;      // Reset release chain.
  logic       rst_n;         // Released reset used by the design.
  logic [1:0] button_sync;   // Zero button synchroniser.

  // Reset asserts at once and releases after two edges.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // The button is a mechanical pin, so it passes two flops first.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      button_sync <= 2'h0;
    end else begin
      button_sync <= {button_sync[0], zero_button};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse counters, one per channel.

  logic [1:0]       test_go;       // Test start levels per channel.
  logic [1:0]       test_go_q;     // Previous test start levels.
  logic [1:0]       test_rise;     // A test run just started.
  logic [CNT_W-1:0] pulse_cnt [2]; // Pulses emitted since last clear.

  assign test_go   = {pulse_test_go_channel1, pulse_test_go_channel0};
  assign test_rise = test_go & ~test_go_q;

  // Test start history; cleared to no test by reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_go_q <= 2'h0;
    end else begin
      test_go_q <= test_go;
    end
  end

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_cnt
      // A clear wins over a pulse in the same cycle: the restart point is that clear.
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pulse_cnt[ch] <= '0;
        end else if (totalizer_clear || test_rise[ch]) begin
          pulse_cnt[ch] <= '0;
        end else if (pulse_emit[ch]) begin
          pulse_cnt[ch] <= pulse_cnt[ch] + 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Alarm outputs and commanded states.

  logic [1:0] next_alarm_cmd;  // Commanded alarm level.
  logic [1:0] alarm_cmd;       // Registered commanded alarm level.

  // In test, a value of 1 pulls the pin low and 0 drives it high.
  assign next_alarm_cmd = (alarm_test_en & ~alarm_test_val) | (~alarm_test_en & alarm_normal);

  // Test controls take effect on the next edge; reset drives both pins low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_cmd <= 2'h0;
    end else begin
      alarm_cmd <= next_alarm_cmd;
    end
  end
  assign alarm_pin = alarm_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Zero button hold timer.

  logic [POS_HOLD_DLY_W-1:0] hold_dly;    // Programmed delay in 50 ms steps.
  logic [$clog2(STEP_CYCLES+1)-1:0] step_div; // Divider for the 50 ms step.
  logic                      step_tick;   // One cycle per 50 ms while held.
  logic [POS_HOLD_DLY_W-1:0] hold_steps;  // Steps counted since press.
  logic                      hold_done;   // Zeroing already started this press.
  logic                      pressed;     // Synchronised button level.

  assign pressed   = button_sync[1];
  assign step_tick = pressed && (step_div == ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1));

  // The divider restarts on each press so that every step is a full 50 ms.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_div <= '0;
    end else if (!pressed || step_tick) begin
      step_div <= '0;
    end else begin
      step_div <= step_div + 1'b1;
    end
  end

  // Counts held steps; one start per press, releasing the button rearms it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_steps <= '0;
      hold_done  <= 1'b0;
      zero_start <= 1'b0;
    end else if (!pressed) begin
      hold_steps <= '0;
      hold_done  <= 1'b0;
      zero_start <= 1'b0;
    end else begin
      zero_start <= !hold_done && (hold_steps >= hold_dly);
      hold_done  <= hold_done || (hold_steps >= hold_dly);
      if (step_tick && hold_steps != '1) begin
        hold_steps <= hold_steps + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access.

  logic        hit_dly;    // Access to the delay holding register.
  logic        hit_ro;     // Access to a read-only input register.
  logic        dly_ok;     // Write value lies in range.
  logic [31:0] ro_data;    // Read data of the input registers.
  pos_rsp_t    next_rsp;   // Answer for the next cycle.

  assign hit_dly = reg_req.addr == POS_ADDR_HOLD_DLY;
  assign dly_ok  = reg_req.wdata <= POS_HOLD_DLY_MAX;
  assign hit_ro  = (reg_req.addr[15:8] == POS_ADDR_FREQ_CH0[15:8] || reg_req.addr[15:8] == POS_ADDR_FREQ_CH1[15:8])
                   && reg_req.addr[7:3] == 5'h00 && !reg_req.addr[0];

  // Input register read data selected by address.
  assign ro_data =
      (reg_req.addr == POS_ADDR_FREQ_CH0)  ? freq_khz_ch0 :
      (reg_req.addr == POS_ADDR_FREQ_CH1)  ? freq_khz_ch1 :
      (reg_req.addr == POS_ADDR_TOTAL_CH0) ? pos_u2f(32'(pulse_cnt[0])) :
      (reg_req.addr == POS_ADDR_TOTAL_CH1) ? pos_u2f(32'(pulse_cnt[1])) :
      (reg_req.addr == POS_ADDR_ALARM0)    ? {31'h0000_0000, alarm_cmd[0]} :
      (reg_req.addr == POS_ADDR_ALARM1)    ? {31'h0000_0000, alarm_cmd[1]} :
      (reg_req.addr == POS_ADDR_AUX_A)     ? {31'h0000_0000, aux_state[0]} :
                                             {31'h0000_0000, aux_state[1]};

  // Answer: writes to input registers, bad delays and unmapped addresses are errors.
  always_comb begin
    next_rsp       = '0;
    next_rsp.ack   = reg_req.valid;
    if (hit_dly) begin
      next_rsp.err   = reg_req.write && !dly_ok;
      next_rsp.rdata = {24'h00_0000, hold_dly};
    end else if (hit_ro) begin
      next_rsp.err   = reg_req.write;
      next_rsp.rdata = reg_req.write ? 32'h0000_0000 : ro_data;
    end else begin
      next_rsp.err   = 1'b1;
    end
    if (!reg_req.valid) begin
      next_rsp = '0;
    end
  end

  // Delay register: only in-range writes are kept; reset restores the default.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_dly <= POS_HOLD_DLY_RESET[POS_HOLD_DLY_W-1:0];
    end else if (reg_req.valid && reg_req.write && hit_dly && dly_ok) begin
      hold_dly <= reg_req.wdata[POS_HOLD_DLY_W-1:0];
    end
  end

  // The answer is registered so data outputs come from flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp <= next_rsp;
    end
  end

endmodule // pos_regs

// file: test/pos_regs_monitor.sv
// Checker for pos_regs: register answers, alarm pins and zero start.
// Assumes it is bound to pos_regs and sees only its ports.
module pos_regs_monitor
  import pos_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire pos_req_t   reg_req,
  input wire pos_rsp_t   reg_rsp,
  input wire logic [1:0] alarm_normal,
  input wire logic [1:0] alarm_test_en,
  input wire logic [1:0] alarm_test_val,
  input wire logic [1:0] alarm_pin,
  input wire logic       zero_button,
  input wire logic       zero_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges since release; pins are held low for two edges after it.
  logic [1:0] live;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) live <= 2'h0;
    else if (live != 2'h3) live <= live + 2'h1;
  end
  wire up = live == 2'h3;
  wire ro_hit = reg_req.addr[15:8] inside {8'h4D, 8'h4E} && reg_req.addr[7:0] inside {8'h00, 8'h02, 8'h04, 8'h06};
  wire dly = reg_req.valid && reg_req.write && reg_req.addr == POS_ADDR_HOLD_DLY;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ack_follows_a: assert property (reg_req.valid |=> reg_rsp.ack) else $error("access not answered");
  ro_write_a: assert property (reg_req.valid && reg_req.write && ro_hit |=> reg_rsp.err && reg_rsp.rdata == 32'h0)
    else $error("read-only write accepted");
  dly_range_a: assert property (dly && reg_req.wdata > POS_HOLD_DLY_MAX |=> reg_rsp.err) else $error("delay over range");
  dly_ok_a: assert property (dly && reg_req.wdata <= POS_HOLD_DLY_MAX |=> !reg_rsp.err) else $error("delay refused");
  unmapped_addr_a: assert property (reg_req.valid && !ro_hit && reg_req.addr != POS_ADDR_HOLD_DLY |=> reg_rsp.err)
    else $error("unmapped access accepted");
  alarm_test_a: assert property (up && alarm_test_en[0] |=> alarm_pin[0] == !$past(alarm_test_val[0]))
    else $error("alarm test level wrong");
  alarm_norm_a: assert property (up && !alarm_test_en[1] |=> alarm_pin[1] == $past(alarm_normal[1]))
    else $error("alarm normal level wrong");
  // The pin passes two synchroniser flops and the start flop, so the press is three edges back.
  zero_cause_a: assert property (zero_start |-> $past(zero_button, 3) ##1 !zero_start) else $error("zero start bad");
  cover property (reg_req.valid && reg_req.write && ro_hit);
  cover property (zero_start);
  cover property (alarm_test_en[0] && alarm_pin[0]);
endmodule // pos_regs_monitor

bind pos_regs pos_regs_monitor i_pos_regs_monitor (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rsp(reg_rsp), .alarm_normal(alarm_normal), .alarm_test_en(alarm_test_en), .alarm_test_val(alarm_test_val),
  .alarm_pin(alarm_pin), .zero_button(zero_button), .zero_start(zero_start));

// file: test/pos_master.sv
// Register master model: one access at a time on the register port.
// Assumes the bench calls access only after reset has been released.
module pos_master
  import pos_pkg::*;
(
  input wire logic sys_clk,
  output pos_req_t reg_req,
  input wire pos_rsp_t reg_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req = '0;
  // Hold the request through the taking edge, then read the answer while it stands.
  task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d, output pos_rsp_t r);
    @(posedge sys_clk);
    reg_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 r = reg_rsp;
  endtask
endmodule // pos_master

// file: test/tb_pos_regs.sv
// Self-checking bench for pos_regs: registers, counts, alarm test, zero button.
// Assumes pos_master drives the register port and the step is cut to 10 clocks.
module tb_pos_regs
  import pos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 10;
  logic sys_clk = 1'b0, rst_b, totalizer_clear, pulse_test_go_channel0, pulse_test_go_channel1, zero_button, zero_start;
  logic [1:0] pulse_emit, alarm_normal, alarm_test_en, alarm_test_val, aux_state, alarm_pin;
  logic [31:0] freq_khz_ch0 = 32'h4120_0000, freq_khz_ch1 = 32'h42C8_0000;
  pos_req_t reg_req;
  pos_rsp_t reg_rsp, r;
  int n_errors = 0, samples_checked = 0, cnt;
  logic [15:0] addrs [8] = '{POS_ADDR_FREQ_CH0, POS_ADDR_TOTAL_CH0, POS_ADDR_ALARM0, POS_ADDR_AUX_A,
                             POS_ADDR_FREQ_CH1, POS_ADDR_TOTAL_CH1, POS_ADDR_ALARM1, POS_ADDR_AUX_B};
  logic [31:0] exp [8] = '{32'h4120_0000, 32'h4040_0000, 32'h1, 32'h0, 32'h42C8_0000, 32'h3F80_0000, 32'h0, 32'h1};
  always #2.5 sys_clk = ~sys_clk;
  pos_regs #(.STEP_CYCLES(STEP)) i_pos_regs (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .freq_khz_ch0(freq_khz_ch0), .freq_khz_ch1(freq_khz_ch1), .pulse_emit(pulse_emit),
    .totalizer_clear(totalizer_clear), .pulse_test_go_channel0(pulse_test_go_channel0),
    .pulse_test_go_channel1(pulse_test_go_channel1), .alarm_normal(alarm_normal), .alarm_test_en(alarm_test_en),
    .alarm_test_val(alarm_test_val), .aux_state(aux_state), .alarm_pin(alarm_pin), .zero_button(zero_button),
    .zero_start(zero_start));
  pos_master i_pos_master (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    i_pos_master.access(1'b0, a, 32'h0, r);
    chk($sformatf("read %h", a), e, r.rdata);
    chk("read err", 32'h0, {31'h0, r.err});
    chk("read ack", 32'h1, {31'h0, r.ack});
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
    i_pos_master.access(1'b1, a, d, r);
    chk($sformatf("write err %h", a), {31'h0, e}, {31'h0, r.err});
    chk("write ack", 32'h1, {31'h0, r.ack});
  endtask
  task automatic do_reset;
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic end_of_test;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    end_of_test;
  end
  initial begin
    {rst_b, totalizer_clear, pulse_test_go_channel0, pulse_test_go_channel1, zero_button} = '0;
    {pulse_emit, alarm_normal, alarm_test_en, alarm_test_val} = '0;
    aux_state = 2'h2;
    do_reset;
    rd(POS_ADDR_HOLD_DLY, POS_HOLD_DLY_RESET);
    wr(POS_ADDR_HOLD_DLY, 32'h0000_00C9, 1'b1);
    wr(POS_ADDR_HOLD_DLY, POS_HOLD_DLY_MAX, 1'b0);
    rd(POS_ADDR_HOLD_DLY, POS_HOLD_DLY_MAX);
    wr(16'h4D01, 32'h1, 1'b1);
    @(posedge sys_clk) pulse_emit <= 2'h3;
    alarm_normal <= 2'h1;
    repeat (2) @(posedge sys_clk) pulse_emit <= 2'h1;
    @(posedge sys_clk) pulse_emit <= 2'h0;
    foreach (addrs[i]) begin
      wr(addrs[i], 32'h1234_5678, 1'b1);
      rd(addrs[i], exp[i]);
    end
    @(posedge sys_clk) pulse_test_go_channel0 <= 1'b1;
    rd(POS_ADDR_TOTAL_CH0, 32'h0);
    rd(POS_ADDR_TOTAL_CH1, 32'h3F80_0000);
    @(posedge sys_clk) totalizer_clear <= 1'b1;
    @(posedge sys_clk) totalizer_clear <= 1'b0;
    rd(POS_ADDR_TOTAL_CH1, 32'h0);
    // Channel 1 test start must restart its own count as well.
    @(posedge sys_clk) pulse_emit <= 2'h2;
    @(posedge sys_clk) pulse_emit <= 2'h0;
    rd(POS_ADDR_TOTAL_CH1, 32'h3F80_0000);
    @(posedge sys_clk) pulse_test_go_channel1 <= 1'b1;
    rd(POS_ADDR_TOTAL_CH1, 32'h0);
    @(posedge sys_clk) alarm_test_en <= 2'h3;
    alarm_test_val <= 2'h1;
    rd(POS_ADDR_ALARM0, 32'h0);
    rd(POS_ADDR_ALARM1, 32'h1);
    chk("alarm pins", 32'h2, {30'h0, alarm_pin});
    wr(POS_ADDR_HOLD_DLY, 32'h2, 1'b0);
    @(posedge sys_clk) zero_button <= 1'b1;
    cnt = 0;
    while (zero_start !== 1'b1 && cnt < 100) begin
      @(posedge sys_clk);
      #1 cnt++;
    end
    chk("zero delay", 32'h1, {31'h0, cnt >= 2 * STEP && cnt <= 2 * STEP + 6});
    @(posedge sys_clk) zero_button <= 1'b0;
    do_reset;
    rd(POS_ADDR_HOLD_DLY, POS_HOLD_DLY_RESET);
    end_of_test;
  end
endmodule // tb_pos_regs
